// *** inc/gpio_pkg.sv ***
// register map, pin function codes and carrier types of the gpio block
package gpio_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int         NUM_PORTS                = 5;
  localparam logic [7:0] OFS_PORT_G_DATA          = 8'h30;
  localparam logic [7:0] OFS_PORT_G_FUNCTION      = 8'h34;
  localparam logic [7:0] OFS_PORT_H_DATA          = 8'h38;
  localparam logic [7:0] OFS_PORT_H_FUNCTION      = 8'h3c;
  localparam logic [7:0] OFS_PORT_I_DATA          = 8'h40;
  localparam logic [7:0] OFS_PORT_I_FUNCTION      = 8'h44;
  localparam logic [7:0] OFS_PORT_J_DATA          = 8'h48;
  localparam logic [7:0] OFS_PORT_J_FUNCTION      = 8'h4c;
  localparam logic [7:0] OFS_PORT_K_DATA          = 8'h50;
  localparam logic [7:0] OFS_PORT_K_FUNCTION      = 8'h54;
  localparam logic [7:0] OFS_PIN_IRQ_TRIGGER_TYPE = 8'h60;
  localparam logic [7:0] OFS_PIN_IRQ_POLARITY     = 8'h64;
  localparam logic [7:0] OFS_PIN_IRQ_ENABLE       = 8'h68;
  localparam logic [7:0] OFS_PIN_IRQ_STATUS_CLEAR = 8'h6c;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int PORT_IDX_LSB  = 3;
  localparam int FNC_SEL_BIT   = 2;
  localparam int LOW_PORT_LSB  = 0;
  localparam int HIGH_PORT_LSB = 8;
  localparam int IRQ_PINS      = 16;

  // ****************************************************************
  // reset values and pin function codes
  // ****************************************************************
  localparam logic [7:0]  RST_DATA = 8'h00;
  localparam logic [15:0] RST_FNC  = 16'h0000;
  localparam logic [15:0] RST_IRQ  = 16'h0000;
  localparam logic [1:0]  FN_INPUT  = 2'h0;
  localparam logic [1:0]  FN_ALT1   = 2'h1;
  localparam logic [1:0]  FN_OUTPUT = 2'h2;
  localparam logic [1:0]  FN_ALT2   = 2'h3;

  // implemented pins and pins allowing function two, ports g to k
  localparam logic [7:0] PIN_IMPL  [NUM_PORTS] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff};
  localparam logic [7:0] ALT2_IMPL [NUM_PORTS] = '{8'hff, 8'hff, 8'h01, 8'h00, 8'h00};

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] alt1;
    logic [7:0] alt2;
  } pin_drive_t;

endpackage

// *** rtl/gpio_ports_with_pin_irq.sv ***
// gpio ports g to k with pin interrupt logic of the low and high ports
`timescale 1ns/1ns

// ****************************************************************
// Operation
// - data register 8 bits; read gives stored value on outputs, pin on inputs
// - two-bit selector: 00 input, 01 function one, 10 output, 11 function two
// - port i has pins 1:0 only; function two on pin 0 only
// - ports j and k reject code 11; input, output, function one only
// - type bit per pin, high port upper byte; 0 level, 1 edge
// - polarity 0: high level or rising edge requests
// - polarity 1: low level or falling edge requests
// - enable bit per pin; 0 blocks, 1 allows the interrupt
// - status bit reads 1 while that pin has a pending request
// - writing 1 to a status bit clears it; writing 0 does nothing
// - enabled ones of the sixteen pin requests ORed onto one shared interrupt line
// - all registers reset to zero: inputs, level high, disabled
// - every register takes 8/16/32-bit accesses by byte lane
// ****************************************************************

module gpio_ports_with_pin_irq
  import gpio_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire wb_req_t               wb_req,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [NUM_PORTS-1:0][7:0] port_pin_in,
  output pin_drive_t [NUM_PORTS-1:0] port_drive,
  input  wire logic [7:0]            low_port_pin_in,
  input  wire logic [7:0]            high_port_pin_in,
  output logic                       shared_pin_interrupt_line
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] byte_merge(
    input logic [31:0] old,
    input logic [31:0] upd,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b+:8] = upd[8*b+:8];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] code_mask(
    input logic [15:0] fnc,
    input logic [1:0]  code
  );
    logic [7:0] res;
    res = 8'h00;
    for (int i = 0; i < 8; i++) begin
      res[i] = (fnc[2*i+:2] == code);
    end
    return res;
  endfunction

  function automatic logic [15:0] legal_fnc(
    input logic [15:0] old,
    input logic [15:0] req,
    input logic [7:0]  impl,
    input logic [7:0]  alt2_ok
  );
    logic [15:0] res;
    res = old;
    for (int i = 0; i < 8; i++) begin
      if (!impl[i]) begin
        res[2*i+:2] = FN_INPUT;
      end else if (req[2*i+:2] != FN_ALT2 || alt2_ok[i]) begin
        res[2*i+:2] = req[2*i+:2];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] data_view(
    input logic [7:0]  stored,
    input logic [7:0]  pins,
    input logic [15:0] fnc,
    input logic [7:0]  impl
  );
    logic [7:0] oe;
    oe = code_mask(fnc, FN_OUTPUT);
    return ((stored & oe) | (pins & ~oe)) & impl;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]                  data_ff [NUM_PORTS];
  logic [15:0]                 fnc_ff [NUM_PORTS];
  logic [15:0]                 type_ff;
  logic [15:0]                 pol_ff;
  logic [15:0]                 ien_ff;
  logic [15:0]                 status_ff;
  logic [15:0]                 nxt_status;
  logic                        ack_ff;
  logic [31:0]                 rdat_ff;
  logic                        irq_ff;
  pin_drive_t [NUM_PORTS-1:0]  drive_ff;
  logic [NUM_PORTS-1:0][7:0]   pin_s1_ff;
  logic [NUM_PORTS-1:0][7:0]   pin_s2_ff;
  logic [IRQ_PINS-1:0]         ab_s1_ff;
  logic [IRQ_PINS-1:0]         ab_s2_ff;
  logic [IRQ_PINS-1:0]         ab_s3_ff;

  logic                        req_take;
  logic                        wr;
  logic [7:0]                  word_adr;
  logic [7:0]                  port_off;
  logic [2:0]                  pidx;
  logic                        hit_port;
  logic                        is_fnc;
  logic [31:0]                 wr_merged;
  logic [15:0]                 clr_mask;
  logic [IRQ_PINS-1:0]         lvl_hit;
  logic [IRQ_PINS-1:0]         edge_hit;
  logic [IRQ_PINS-1:0]         cond_hit;
  logic [31:0]                 rd_mux;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign req_take = wb_req.cyc && wb_req.stb && !ack_ff;
  assign wr       = req_take && wb_req.we;
  assign word_adr = {wb_req.adr[7:2], 2'b00};
  assign port_off = word_adr - OFS_PORT_G_DATA;
  assign pidx     = port_off[PORT_IDX_LSB+:3];
  assign is_fnc   = port_off[FNC_SEL_BIT];
  assign hit_port = (word_adr >= OFS_PORT_G_DATA) && (word_adr <= OFS_PORT_K_FUNCTION);

  // byte lanes apply to every register alike
  assign wr_merged = byte_merge(32'h0000_0000, wb_req.dat, wb_req.sel);

  // ****************************************************************
  // wishbone answer
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else if (ce) begin
      ack_ff <= req_take;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_port) begin
      if (is_fnc) begin
        rd_mux[15:0] = fnc_ff[pidx];
      end else begin
        rd_mux[7:0] = data_view(data_ff[pidx], pin_s2_ff[pidx],
                                fnc_ff[pidx], PIN_IMPL[pidx]);
      end
    end else begin
      case (word_adr)
        OFS_PIN_IRQ_TRIGGER_TYPE: rd_mux[15:0] = type_ff;
        OFS_PIN_IRQ_POLARITY:     rd_mux[15:0] = pol_ff;
        OFS_PIN_IRQ_ENABLE:       rd_mux[15:0] = ien_ff;
        OFS_PIN_IRQ_STATUS_CLEAR: rd_mux[15:0] = status_ff;
        default:                  rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdat_ff <= 32'h0000_0000;
    end else if (ce) begin
      rdat_ff <= (req_take && !wb_req.we) ? rd_mux : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      ab_s1_ff  <= '0;
      ab_s2_ff  <= '0;
      ab_s3_ff  <= '0;
    end else if (ce) begin
      pin_s1_ff <= port_pin_in;
      pin_s2_ff <= pin_s1_ff;
      ab_s1_ff  <= {high_port_pin_in, low_port_pin_in};
      ab_s2_ff  <= ab_s1_ff;
      ab_s3_ff  <= ab_s2_ff;
    end
  end

  // ****************************************************************
  // port data and function registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        data_ff[p] <= RST_DATA;
      end
    end else if (ce && wr && hit_port && !is_fnc) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (pidx == 3'(p)) begin
          data_ff[p] <= 8'(byte_merge({24'h0, data_ff[p]}, wb_req.dat,
                                      wb_req.sel)) & PIN_IMPL[p];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        fnc_ff[p] <= RST_FNC;
      end
    end else if (ce && wr && hit_port && is_fnc) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (pidx == 3'(p)) begin
          // unsupported codes keep the old selector
          fnc_ff[p] <= legal_fnc(fnc_ff[p],
                                 16'(byte_merge({16'h0, fnc_ff[p]}, wb_req.dat,
                                                wb_req.sel)),
                                 PIN_IMPL[p], ALT2_IMPL[p]);
        end
      end
    end
  end

  // pad drivers decoded from the selectors
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_ff <= '0;
    end else if (ce) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        drive_ff[p].out  <= data_ff[p];
        drive_ff[p].oe   <= code_mask(fnc_ff[p], FN_OUTPUT);
        drive_ff[p].alt1 <= code_mask(fnc_ff[p], FN_ALT1);
        drive_ff[p].alt2 <= code_mask(fnc_ff[p], FN_ALT2);
      end
    end
  end

  assign port_drive = drive_ff;

  // ****************************************************************
  // interrupt configuration
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      type_ff <= RST_IRQ;
      pol_ff  <= RST_IRQ;
      ien_ff  <= RST_IRQ;
    end else if (ce && wr) begin
      if (word_adr == OFS_PIN_IRQ_TRIGGER_TYPE) begin
        type_ff <= 16'(byte_merge({16'h0, type_ff}, wb_req.dat, wb_req.sel));
      end
      if (word_adr == OFS_PIN_IRQ_POLARITY) begin
        pol_ff <= 16'(byte_merge({16'h0, pol_ff}, wb_req.dat, wb_req.sel));
      end
      if (word_adr == OFS_PIN_IRQ_ENABLE) begin
        ien_ff <= 16'(byte_merge({16'h0, ien_ff}, wb_req.dat, wb_req.sel));
      end
    end
  end

  // ****************************************************************
  // request detection and status
  // ****************************************************************
  assign lvl_hit  = ~type_ff & (ab_s2_ff ^ pol_ff);
  assign edge_hit = type_ff & ((~pol_ff & ab_s2_ff & ~ab_s3_ff)
                             | (pol_ff & ~ab_s2_ff & ab_s3_ff));
  assign cond_hit = lvl_hit | edge_hit;

  assign clr_mask = (wr && word_adr == OFS_PIN_IRQ_STATUS_CLEAR) ? wr_merged[15:0] : 16'h0000;

  // a new request wins over a clear in the same cycle
  assign nxt_status = (status_ff & ~clr_mask) | cond_hit;

  always_ff @(posedge clk) begin
    if (rst) begin
      status_ff <= RST_IRQ;
    end else if (ce) begin
      status_ff <= nxt_status;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= |(nxt_status & ien_ff);
    end
  end

  assign shared_pin_interrupt_line = irq_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst || !ce);

  sequence s_take;
    wb_req.cyc && wb_req.stb && !wb_ack_o;
  endsequence

  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_ack_once: assert property (s_take |=> s_answer)
    else $error("ack not a single cycle after request");

  a_data_read: assert property (
    s_take and (!wb_req.we && word_adr == OFS_PORT_G_DATA)
    |=> wb_dat_o[7:0] == data_view($past(data_ff[0]), $past(pin_s2_ff[0]),
                                   $past(fnc_ff[0]), PIN_IMPL[0]))
    else $error("data read mixes stored and pin bits wrongly");

  a_port_i_pins: assert property (
    fnc_ff[2][15:4] == 12'h000 && fnc_ff[2][3:2] != FN_ALT2
    && data_ff[2][7:2] == 6'h00)
    else $error("port i holds an unimplemented pin setting");

  a_no_alt2_jk: assert property (
    code_mask(fnc_ff[3], FN_ALT2) == 8'h00
    && code_mask(fnc_ff[4], FN_ALT2) == 8'h00)
    else $error("ports j or k hold reserved code");

  a_level_hit: assert property (
    |lvl_hit |=> (status_ff & $past(lvl_hit)) == $past(lvl_hit))
    else $error("level request not latched");

  a_edge_rise: assert property (
    |(type_ff & ~pol_ff & ab_s2_ff & ~ab_s3_ff)
    |=> |(status_ff & $past(type_ff & ~pol_ff)))
    else $error("rising edge request not latched");

  a_edge_fall: assert property (
    |(type_ff & pol_ff & ~ab_s2_ff & ab_s3_ff)
    |=> |(status_ff & $past(type_ff & pol_ff)))
    else $error("falling edge request not latched");

  a_status_sticky: assert property (
    |status_ff && clr_mask == 16'h0000
    |=> (status_ff & $past(status_ff)) == $past(status_ff))
    else $error("status bit dropped without a clear");

  a_w1c_clears: assert property (
    clr_mask != 16'h0000
    |=> (status_ff & $past(clr_mask) & ~$past(cond_hit)) == 16'h0000)
    else $error("write one did not clear status");

  a_irq_line: assert property (
    shared_pin_interrupt_line == |(status_ff & $past(ien_ff)))
    else $error("shared line disagrees with status and enable");

  a_reset_zero: assert property (
    $past(rst) |-> type_ff == RST_IRQ && pol_ff == RST_IRQ && ien_ff == RST_IRQ
                   && fnc_ff[0] == RST_FNC && data_ff[0] == RST_DATA)
    else $error("register not zero after reset");

endmodule

// *** tb/gpio_pin_partner.sv ***
// model of the pins and the interrupt controller around the gpio block
`timescale 1ns/1ns

module gpio_pin_partner
  import gpio_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire pin_drive_t [NUM_PORTS-1:0] port_drive,
  input  wire logic [NUM_PORTS-1:0][7:0]  ext_level,
  input  wire logic [15:0]                irq_pins,
  input  wire logic                       shared_pin_interrupt_line,
  output logic [NUM_PORTS-1:0][7:0]       port_pin_in,
  output logic [7:0]                      low_port_pin_in,
  output logic [7:0]                      high_port_pin_in,
  output logic [7:0]                      irq_rises
);
  logic       line_ff;
  logic [7:0] irq_rises_ff;

  // ****************************************************************
  // pads: a driven pin reads back its own level
  // ****************************************************************
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_pin_in[p] = (port_drive[p].oe & port_drive[p].out) |
                       (~port_drive[p].oe & ext_level[p]);
    end
  end
  assign low_port_pin_in  = irq_pins[7:0];
  assign high_port_pin_in = irq_pins[15:8];

  // ****************************************************************
  // interrupt controller: counts requests on the shared line
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      line_ff      <= 1'b0;
      irq_rises_ff <= 8'h00;
    end else begin
      line_ff <= shared_pin_interrupt_line;
      if (shared_pin_interrupt_line && !line_ff) begin
        irq_rises_ff <= irq_rises_ff + 8'h01;
      end
    end
  end
  assign irq_rises = irq_rises_ff;
endmodule

// *** tb/test_gpio_ports_with_pin_irq.sv ***
// self-checking bench of the gpio block
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("Error at %0t: got %h expected %h", $time, a, b); end end

module test_gpio_ports_with_pin_irq
  import gpio_pkg::*;
;
  typedef struct packed {
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
    logic [31:0] exp;
  } row_t;

  logic                       clk;
  logic                       rst;
  logic                       ce;
  wb_req_t                    wb_req;
  logic [31:0]                wb_dat_o;
  logic                       wb_ack_o;
  logic [NUM_PORTS-1:0][7:0]  port_pin_in;
  logic [NUM_PORTS-1:0][7:0]  ext_level;
  pin_drive_t [NUM_PORTS-1:0] port_drive;
  logic [7:0]                 low_port_pin_in;
  logic [7:0]                 high_port_pin_in;
  logic [7:0]                 irq_rises;
  logic [15:0]                irq_pins;
  logic                       shared_pin_interrupt_line;
  logic [31:0]                rd;
  int                         mismatches;
  int                         checks;

  row_t rows [21] = '{
    '{1'h1, 8'h34, 4'hf, 32'haaaa, 32'h0}, '{1'h0, 8'h34, 4'hf, 32'h0, 32'haaaa},
    '{1'h1, 8'h30, 4'h1, 32'h5a, 32'h0}, '{1'h1, 8'h30, 4'h2, 32'hff00, 32'h0},
    '{1'h0, 8'h30, 4'hf, 32'h0, 32'h5a}, '{1'h1, 8'h44, 4'hf, 32'hffff, 32'h0},
    '{1'h0, 8'h44, 4'hf, 32'h0, 32'h3}, '{1'h1, 8'h44, 4'hf, 32'h4, 32'h0},
    '{1'h0, 8'h44, 4'hf, 32'h0, 32'h4}, '{1'h0, 8'h40, 4'hf, 32'h0, 32'h3},
    '{1'h1, 8'h4c, 4'hf, 32'hffff, 32'h0}, '{1'h0, 8'h4c, 4'hf, 32'h0, 32'h0},
    '{1'h1, 8'h54, 4'hf, 32'h5599, 32'h0}, '{1'h1, 8'h54, 4'hf, 32'hffff, 32'h0},
    '{1'h0, 8'h54, 4'hf, 32'h0, 32'h5599}, '{1'h0, 8'h38, 4'hf, 32'h0, 32'h3c},
    '{1'h1, 8'h58, 4'hf, 32'h1234, 32'h0}, '{1'h0, 8'h58, 4'hf, 32'h0, 32'h0},
    '{1'h1, 8'h64, 4'h3, 32'h12345678, 32'h0}, '{1'h0, 8'h64, 4'hf, 32'h0, 32'h5678},
    '{1'h1, 8'h64, 4'hf, 32'h0, 32'h0}};

  gpio_ports_with_pin_irq i_dut (
    .clk                       (clk),
    .rst                       (rst),
    .ce                        (ce),
    .wb_req                    (wb_req),
    .wb_dat_o                  (wb_dat_o),
    .wb_ack_o                  (wb_ack_o),
    .port_pin_in               (port_pin_in),
    .port_drive                (port_drive),
    .low_port_pin_in           (low_port_pin_in),
    .high_port_pin_in          (high_port_pin_in),
    .shared_pin_interrupt_line (shared_pin_interrupt_line)
  );

  gpio_pin_partner i_partner (
    .clk                       (clk),
    .rst                       (rst),
    .port_drive                (port_drive),
    .ext_level                 (ext_level),
    .irq_pins                  (irq_pins),
    .shared_pin_interrupt_line (shared_pin_interrupt_line),
    .port_pin_in               (port_pin_in),
    .low_port_pin_in           (low_port_pin_in),
    .high_port_pin_in          (high_port_pin_in),
    .irq_rises                 (irq_rises)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ****************************************************************
  // bus cycle and helpers
  // ****************************************************************
  task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                     input logic [31:0] dat, output logic [31:0] q);
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] q;
    bus(1'b1, adr, 4'hf, dat, q);
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, adr, 4'hf, 32'h0, q);
    `CHK(q, exp)
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    test_done();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    wb_req     = '0;
    rst        = 1'b1;
    ce         = 1'b1;
    ext_level  = '0;
    irq_pins   = 16'h0000;
    mismatches = 0;
    checks     = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 'h30; a <= 'h6c; a += 4) begin
      rdc(8'(a), 32'h0);
    end
    ext_level[1] <= 8'h3c;
    ext_level[2] <= 8'hff;
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat, rd);
      if (!rows[i].we) `CHK(rd, rows[i].exp)
    end
    `CHK(port_drive[0].oe, 8'hff)
    `CHK(port_drive[0].out, 8'h5a)
    `CHK(port_drive[2].alt1, 8'h02)
    `CHK(port_drive[4].alt1, 8'hf5)
    `CHK(port_drive[4].alt2, 8'h00)
    // active-low polarity left requests behind
    wr(OFS_PIN_IRQ_STATUS_CLEAR, 32'hffff);
    // level high request, write of zero, clear after the level goes
    wr(OFS_PIN_IRQ_ENABLE, 32'h0001);
    irq_pins[0] <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0001);
    `CHK(shared_pin_interrupt_line, 1'b1)
    wr(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0000);
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0001);
    irq_pins[0] <= 1'b0;
    repeat (6) @(posedge clk);
    wr(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0001);
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0000);
    `CHK(shared_pin_interrupt_line, 1'b0)
    // masked pin of the high port
    irq_pins[9] <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0200);
    `CHK(shared_pin_interrupt_line, 1'b0)
    irq_pins[9] <= 1'b0;
    repeat (6) @(posedge clk);
    wr(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0200);
    // short rising pulse in edge mode stays pending
    wr(OFS_PIN_IRQ_TRIGGER_TYPE, 32'h0004);
    wr(OFS_PIN_IRQ_STATUS_CLEAR, 32'hffff);
    irq_pins[2] <= 1'b1;
    repeat (2) @(posedge clk);
    irq_pins[2] <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0004);
    wr(OFS_PIN_IRQ_ENABLE, 32'h0005);
    repeat (2) @(posedge clk);
    `CHK(shared_pin_interrupt_line, 1'b1)
    `CHK(irq_rises, 8'h02)
    wr(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0004);
    wr(OFS_PIN_IRQ_ENABLE, 32'h0000);
    // falling edge, active low
    irq_pins[10] <= 1'b1;
    wr(OFS_PIN_IRQ_TRIGGER_TYPE, 32'h0404);
    wr(OFS_PIN_IRQ_POLARITY, 32'h0400);
    repeat (6) @(posedge clk);
    wr(OFS_PIN_IRQ_STATUS_CLEAR, 32'hffff);
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0000);
    irq_pins[10] <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0400);
    // low level request
    wr(OFS_PIN_IRQ_TRIGGER_TYPE, 32'h0000);
    wr(OFS_PIN_IRQ_POLARITY, 32'h0800);
    wr(OFS_PIN_IRQ_STATUS_CLEAR, 32'hffff);
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0800);
    // reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0000);
    rdc(OFS_PIN_IRQ_POLARITY, 32'h0000);
    rdc(OFS_PORT_G_FUNCTION, 32'h0000);
    `CHK(port_drive[0], 32'h0)
    // clock enable low freezes the pin path
    ce <= 1'b0;
    irq_pins[3] <= 1'b1;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0000);
    repeat (6) @(posedge clk);
    rdc(OFS_PIN_IRQ_STATUS_CLEAR, 32'h0008);
    test_done();
  end
endmodule
